//--- hdl/rx_slot_map_map.vh
// Purpose: Constants for the secondary audio receive slot map
// Assumes: Included by the slot map design file only
// Notes:   Offsets are register addresses on the control port
`ifndef RX_SLOT_MAP_MAP_VH
`define RX_SLOT_MAP_MAP_VH

// Register addresses
`define ADDR_RX_MSB_DELAY    8'h26
`define ADDR_RX_PIN_SELECT   8'h27
`define ADDR_RX_CH1_CONFIG   8'h28
`define ADDR_RX_CH2_CONFIG   8'h29

// Reset values
`define RST_RX_MSB_DELAY     5'h00
`define RST_RX_PIN_SELECT    8'h00
`define RST_RX_CH1_CONFIG    8'h00
`define RST_RX_CH2_CONFIG    8'h01

// Channel config fields
`define CFG_ENABLE_BIT       5
`define CFG_SLOT_MSB         4
`define CFG_SLOT_LSB         0
`define CFG_WRITE_MASK       8'h3F

// Slot field split for two-half formats
`define SLOT_HALF_BIT        4
`define SLOT_SAT             6'h3F

// Frame formats
`define FMT_TDM              2'h0
`define FMT_I2S              2'h1
`define FMT_LJ               2'h2

// Word lengths
`define WL_16                2'h0
`define WL_20                2'h1
`define WL_24                2'h2
`define WL_32                2'h3
`define WL_16_LAST           5'h0F
`define WL_20_LAST           5'h13
`define WL_24_LAST           5'h17
`define WL_32_LAST           5'h1F

`endif

//--- hdl/secondary_audio_rx_slot_map.v
// Purpose: Receive channel slot map of the secondary audio serial port
// Assumes: bclk, fsync and data pins are asynchronous; clk_in far faster than bclk
// Notes:   Data sampled on bclk rising edge; samples left-justified in 32 bits
`timescale 1ns/10ps
`include "rx_slot_map_map.vh"

module secondary_audio_rx_slot_map
(
  input  wire        clk_in,
  input  wire        rstn_in,
  input  wire [7:0]  reg_addr_in,
  input  wire [7:0]  reg_wdata_in,
  input  wire        reg_wr_in,
  input  wire        reg_rd_in,
  output reg  [7:0]  reg_rdata_out,
  input  wire [1:0]  frame_format_in,
  input  wire [1:0]  word_length_in,
  input  wire        bit_clock_in,
  input  wire        frame_sync_in,
  input  wire        data_in,
  input  wire        second_data_in,
  output reg  [31:0] playback_ch1_data_out,
  output reg         playback_ch1_valid_out,
  output reg  [31:0] playback_ch2_data_out,
  output reg         playback_ch2_valid_out
);

  reg  [4:0]  rx_slot0_msb_delay_reg;
  reg  [7:0]  secondary_rx_pin_select_reg;
  reg  [7:0]  secondary_rx_channel1_config_reg;
  reg  [7:0]  secondary_rx_channel2_config_reg;
  reg  [1:0]  bclk_sync_reg;
  reg  [1:0]  fsync_sync_reg;
  reg  [1:0]  din_sync_reg;
  reg  [1:0]  data2_sync_reg;
  reg         bclk_last_reg;
  reg         fsync_last_reg;
  reg  [5:0]  skip_reg;
  reg  [4:0]  bit_reg;
  reg  [5:0]  slot_reg;
  reg         half_reg;
  reg         started_reg;
  reg  [31:0] ch1_shift_reg;
  reg  [31:0] ch2_shift_reg;

  wire        bclk_rise;
  wire        fsync_change;
  wire        half_start;
  wire        new_half;
  reg  [5:0]  cur_skip;
  reg  [4:0]  cur_bit;
  reg  [5:0]  cur_slot;
  reg         cur_half;
  reg  [4:0]  last_bit;
  reg  [5:0]  std_delay;
  reg  [5:0]  eff_slot;
  wire        capture;
  wire        word_end;
  wire        ch1_en;
  wire        ch2_en;
  wire        ch1_bit;
  wire        ch2_bit;
  wire        ch1_hit;
  wire        ch2_hit;
  wire [31:0] ch1_word;
  wire [31:0] ch2_word;

  // Register writes; reserved config bits forced to zero
  always @(posedge clk_in)
  begin
    if (!rstn_in)
    begin
      rx_slot0_msb_delay_reg           <= `RST_RX_MSB_DELAY;
      secondary_rx_pin_select_reg      <= `RST_RX_PIN_SELECT;
      secondary_rx_channel1_config_reg <= `RST_RX_CH1_CONFIG;
      secondary_rx_channel2_config_reg <= `RST_RX_CH2_CONFIG;
    end
    else if (reg_wr_in)
    begin
      case (reg_addr_in)
        `ADDR_RX_MSB_DELAY:  rx_slot0_msb_delay_reg      <= reg_wdata_in[4:0];
        `ADDR_RX_PIN_SELECT: secondary_rx_pin_select_reg <= reg_wdata_in;
        `ADDR_RX_CH1_CONFIG:
          secondary_rx_channel1_config_reg <= reg_wdata_in & `CFG_WRITE_MASK;
        `ADDR_RX_CH2_CONFIG:
          secondary_rx_channel2_config_reg <= reg_wdata_in & `CFG_WRITE_MASK;
        default: ;
      endcase
    end
  end

  // Register reads; unmapped addresses read zero
  always @(posedge clk_in)
  begin
    if (!rstn_in)
      reg_rdata_out <= 8'h00;
    else if (reg_rd_in)
    begin
      case (reg_addr_in)
        `ADDR_RX_MSB_DELAY:  reg_rdata_out <= {3'h0, rx_slot0_msb_delay_reg};
        `ADDR_RX_PIN_SELECT: reg_rdata_out <= secondary_rx_pin_select_reg;
        `ADDR_RX_CH1_CONFIG: reg_rdata_out <= secondary_rx_channel1_config_reg;
        `ADDR_RX_CH2_CONFIG: reg_rdata_out <= secondary_rx_channel2_config_reg;
        default:             reg_rdata_out <= 8'h00;
      endcase
    end
  end

  // Two-stage synchronisers for the link pins
  always @(posedge clk_in)
  begin
    if (!rstn_in)
    begin
      bclk_sync_reg  <= 2'h0;
      fsync_sync_reg <= 2'h0;
      din_sync_reg   <= 2'h0;
      data2_sync_reg <= 2'h0;
      bclk_last_reg  <= 1'h0;
      fsync_last_reg <= 1'h0;
    end
    else
    begin
      bclk_sync_reg  <= {bclk_sync_reg[0], bit_clock_in};
      fsync_sync_reg <= {fsync_sync_reg[0], frame_sync_in};
      din_sync_reg   <= {din_sync_reg[0], data_in};
      data2_sync_reg <= {data2_sync_reg[0], second_data_in};
      bclk_last_reg  <= bclk_sync_reg[1];
      if (bclk_rise)
        fsync_last_reg <= fsync_sync_reg[1];
    end
  end

  assign bclk_rise    = bclk_sync_reg[1] & ~bclk_last_reg;
  assign fsync_change = bclk_rise & (fsync_sync_reg[1] != fsync_last_reg);
  // TDM frames start on the rising sync edge only; two-half formats on either
  assign half_start   = fsync_change &
                        ((frame_format_in != `FMT_TDM) | fsync_sync_reg[1]);
  // Left half: sync low in I2S, sync high in LJ
  assign new_half     = (frame_format_in == `FMT_I2S) ? fsync_sync_reg[1]
                                                      : ~fsync_sync_reg[1];

  // Bit position for this bit clock, including start of a new half
  always @*
  begin
    std_delay = (frame_format_in == `FMT_I2S) ? 6'h01 : 6'h00;
    cur_skip  = half_start ? (std_delay + {1'b0, rx_slot0_msb_delay_reg}) : skip_reg;
    cur_bit   = half_start ? 5'h00 : bit_reg;
    cur_slot  = half_start ? 6'h00 : slot_reg;
    cur_half  = half_start ? new_half : half_reg;
    case (word_length_in)
      `WL_16:  last_bit = `WL_16_LAST;
      `WL_20:  last_bit = `WL_20_LAST;
      `WL_24:  last_bit = `WL_24_LAST;
      default: last_bit = `WL_32_LAST;
    endcase
    // Slot numbering: TDM counts on, two-half formats put right half at 16
    if (frame_format_in == `FMT_TDM)
      eff_slot = cur_slot;
    else if (cur_slot[5:4] != 2'h0)
      eff_slot = `SLOT_SAT;
    else
      eff_slot = {1'b0, cur_half, cur_slot[3:0]};
  end

  assign capture  = bclk_rise & (started_reg | half_start) & (cur_skip == 6'h00);
  assign word_end = capture & (cur_bit == last_bit);

  // Bit, slot and half counters
  always @(posedge clk_in)
  begin
    if (!rstn_in)
    begin
      skip_reg    <= 6'h00;
      bit_reg     <= 5'h00;
      slot_reg    <= 6'h00;
      half_reg    <= 1'h0;
      started_reg <= 1'h0;
    end
    else if (bclk_rise & (started_reg | half_start))
    begin
      started_reg <= 1'h1;
      half_reg    <= cur_half;
      if (cur_skip != 6'h00)
      begin
        skip_reg <= cur_skip - 6'h01;
        bit_reg  <= cur_bit;
        slot_reg <= cur_slot;
      end
      else
      begin
        skip_reg <= 6'h00;
        if (cur_bit == last_bit)
        begin
          bit_reg  <= 5'h00;
          slot_reg <= (cur_slot == `SLOT_SAT) ? cur_slot : cur_slot + 6'h01;
        end
        else
        begin
          bit_reg  <= cur_bit + 5'h01;
          slot_reg <= cur_slot;
        end
      end
    end
  end

  // Channel pin choice and slot match
  assign ch1_en  = secondary_rx_channel1_config_reg[`CFG_ENABLE_BIT];
  assign ch2_en  = secondary_rx_channel2_config_reg[`CFG_ENABLE_BIT];
  assign ch1_bit = secondary_rx_pin_select_reg[0] ? data2_sync_reg[1] : din_sync_reg[1];
  assign ch2_bit = secondary_rx_pin_select_reg[1] ? data2_sync_reg[1] : din_sync_reg[1];
  assign ch1_hit = capture &
    (eff_slot == {1'b0, secondary_rx_channel1_config_reg[`CFG_SLOT_MSB:`CFG_SLOT_LSB]});
  assign ch2_hit = capture &
    (eff_slot == {1'b0, secondary_rx_channel2_config_reg[`CFG_SLOT_MSB:`CFG_SLOT_LSB]});
  assign ch1_word = {ch1_shift_reg[30:0], ch1_bit} << (5'h1F - last_bit);
  assign ch2_word = {ch2_shift_reg[30:0], ch2_bit} << (5'h1F - last_bit);

  // Shift slot bits in and hand whole words to playback
  always @(posedge clk_in)
  begin
    if (!rstn_in)
    begin
      ch1_shift_reg          <= 32'h00000000;
      ch2_shift_reg          <= 32'h00000000;
      playback_ch1_data_out  <= 32'h00000000;
      playback_ch2_data_out  <= 32'h00000000;
      playback_ch1_valid_out <= 1'h0;
      playback_ch2_valid_out <= 1'h0;
    end
    else
    begin
      playback_ch1_valid_out <= ch1_en & ch1_hit & word_end;
      playback_ch2_valid_out <= ch2_en & ch2_hit & word_end;
      if (ch1_hit)
        ch1_shift_reg <= {ch1_shift_reg[30:0], ch1_bit};
      if (ch2_hit)
        ch2_shift_reg <= {ch2_shift_reg[30:0], ch2_bit};
      if (!ch1_en)
        playback_ch1_data_out <= 32'h00000000;
      else if (ch1_hit & word_end)
        playback_ch1_data_out <= ch1_word;
      if (!ch2_en)
        playback_ch2_data_out <= 32'h00000000;
      else if (ch2_hit & word_end)
        playback_ch2_data_out <= ch2_word;
    end
  end

endmodule

//--- sim/rx_slot_map_props.sv
// Purpose: Port assertions for the receive slot map
// Assumes: Register writes mirrored in local shadows
// Notes:   Bound to every slot map instance
`timescale 1ns/10ps
module rx_slot_map_props (
  input logic        clk_in,
  input logic        rstn_in,
  input logic [7:0]  reg_addr_in,
  input logic [7:0]  reg_wdata_in,
  input logic        reg_wr_in,
  input logic        reg_rd_in,
  input logic [7:0]  reg_rdata_out,
  input logic [31:0] playback_ch1_data_out,
  input logic        playback_ch1_valid_out,
  input logic        playback_ch2_valid_out
);
  logic [7:0] sel_sh;
  logic [5:0] c1_sh, c2_sh;
  // Shadows of the writable pin select and channel config bits
  always @(posedge clk_in)
    if (!rstn_in)
      {sel_sh, c1_sh, c2_sh} <= 20'h00001;
    else if (reg_wr_in)
      case (reg_addr_in)
        8'h27: sel_sh <= reg_wdata_in;
        8'h28: c1_sh <= reg_wdata_in[5:0];
        8'h29: c2_sh <= reg_wdata_in[5:0];
        default: ;
      endcase
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rstn_in);
  a_sel_read: assert property (reg_rd_in && reg_addr_in == 8'h27
    |=> reg_rdata_out == $past(sel_sh)) else $error("pin select read wrong");
  a_ch1_read: assert property (reg_rd_in && reg_addr_in == 8'h28
    |=> reg_rdata_out == {2'h0, $past(c1_sh)}) else $error("ch1 config read wrong");
  a_ch2_read: assert property (reg_rd_in && reg_addr_in == 8'h29
    |=> reg_rdata_out == {2'h0, $past(c2_sh)}) else $error("ch2 config read wrong");
  a_ch1_quiet: assert property (!c1_sh[5] [*3] |-> !playback_ch1_valid_out
    && playback_ch1_data_out == 32'h0) else $error("disabled ch1 active");
  a_ch2_quiet: assert property (!c2_sh[5] [*3] |-> !playback_ch2_valid_out)
    else $error("disabled ch2 active");
  a_ch1_pulse: assert property (playback_ch1_valid_out |=> !playback_ch1_valid_out)
    else $error("ch1 valid too long");
  a_ch2_pulse: assert property (playback_ch2_valid_out |=> !playback_ch2_valid_out)
    else $error("ch2 valid too long");
  a_ch1_hold: assert property (c1_sh[5] && $past(c1_sh[5]) && !playback_ch1_valid_out
    |-> $stable(playback_ch1_data_out)) else $error("ch1 data moved");
  c_ch1_data: cover property (playback_ch1_valid_out);
  c_ch2_data: cover property (playback_ch2_valid_out);
  c_cfg_write: cover property (reg_wr_in && reg_addr_in == 8'h28);
endmodule
bind secondary_audio_rx_slot_map rx_slot_map_props i_rx_slot_map_props (.*);

//--- sim/host_frame_drv.sv
// Purpose: Host frame source for the slot map bench
// Assumes: 32 slots of 16 bits; lines change while bit clock is low
// Notes:   Bit clock stands still between frames
`timescale 1ns/10ps
module host_frame_drv (
  output logic bclk_out,
  output logic fsync_out,
  output logic d0_out,
  output logic d1_out
);
  // Idle levels
  initial
    {bclk_out, fsync_out, d0_out, d1_out} = 4'h1;
  // One frame; word carries pin tag and slot position
  task automatic frame(input logic [1:0] f, input int off);
    int j;
    logic [15:0] w0, w1;
    for (int i = -1; i < 520; i++)
    begin
      j = i - off - int'(f == 2'h1);
      w0 = {8'hC3, 3'h0, 5'(j / 16)};
      w1 = {8'h3C, 3'h0, 5'(j / 16)};
      fsync_out = i < 0 ? f == 2'h1 : f == 2'h0 ? i == 0 : (i > 255) ^ (f != 2'h1);
      d0_out = j >= 0 && j < 512 ? w0[15 - j % 16] : ~d0_out;
      d1_out = j >= 0 && j < 512 ? w1[15 - j % 16] : ~d1_out;
      #62.5 bclk_out = 1'h1;
      #62.5 bclk_out = 1'h0;
    end
  endtask
endmodule

//--- sim/secondary_audio_rx_slot_map_tb.sv
// Purpose: Self-checking bench for the receive slot map
// Assumes: 16-bit slots except the one 32-bit slot scenario; host model makes all link traffic
// Notes:   Register checks in one task; all link scenarios share t_scenarios
`timescale 1ns/10ps
module secondary_audio_rx_slot_map_tb;
  logic        clk_in, rstn_in, reg_wr_in, reg_rd_in, bit_clock_in, frame_sync_in;
  logic        data_in, second_data_in, playback_ch1_valid_out, playback_ch2_valid_out;
  logic [7:0]  reg_addr_in, reg_wdata_in, reg_rdata_out;
  logic [1:0]  frame_format_in, word_length_in;
  logic [31:0] playback_ch1_data_out, playback_ch2_data_out, got1, got2;
  int          num_errors, total_checks, cycles, n1;
  secondary_audio_rx_slot_map i_secondary_audio_rx_slot_map (.*);
  host_frame_drv i_host_frame_drv (.bclk_out(bit_clock_in), .fsync_out(frame_sync_in),
    .d0_out(data_in), .d1_out(second_data_in));
  // Clock
  initial
  begin
    clk_in = 1'h0;
    forever #5 clk_in = ~clk_in;
  end
  // Sample capture and run limit
  always @(posedge clk_in)
  begin
    cycles++;
    n1 += int'(playback_ch1_valid_out === 1'h1);
    if (playback_ch1_valid_out === 1'h1)
      got1 = playback_ch1_data_out;
    if (playback_ch2_valid_out === 1'h1)
      got2 = playback_ch2_data_out;
    if (cycles == 60000)
    begin
      num_errors++;
      test_done();
    end
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("ERROR at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  function automatic logic [31:0] word(input logic p, input logic [4:0] s);
    return {p ? 8'h3C : 8'hC3, 3'h0, s, 16'h0000};
  endfunction
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_in);
    {reg_addr_in, reg_wdata_in, reg_wr_in} = {a, d, 1'h1};
    @(negedge clk_in);
    reg_wr_in = 1'h0;
  endtask
  task automatic rc(input logic [7:0] a, input logic [7:0] e);
    @(negedge clk_in);
    {reg_addr_in, reg_rd_in} = {a, 1'h1};
    @(negedge clk_in);
    reg_rd_in = 1'h0;
    @(negedge clk_in);
    chk({24'h0, reg_rdata_out}, {24'h0, e});
  endtask
  task automatic run(input logic [1:0] f, input int off, input logic [7:0] sel, c1, c2);
    wr(8'h26, 8'(off));
    wr(8'h27, sel);
    wr(8'h28, c1);
    wr(8'h29, c2);
    frame_format_in = f;
    {n1, got1, got2} = 0;
    i_host_frame_drv.frame(f, off);
    repeat (20) @(negedge clk_in);
  endtask
  task automatic t_regs();
    rc(8'h26, 8'h00);
    rc(8'h27, 8'h00);
    rc(8'h28, 8'h00);
    rc(8'h29, 8'h01);
    rc(8'h40, 8'h00);
    wr(8'h27, 8'hA5);
    rc(8'h27, 8'hA5);
    wr(8'h28, 8'hFF);
    rc(8'h28, 8'h3F);
  endtask
  task automatic t_scenarios();
    run(2'h0, 0, 8'h02, 8'h20, 8'h3F);
    chk(32'(n1), 32'h1);
    chk(got1, word(0, 5'h00));
    chk(got2, word(1, 5'h1F));
    for (int f = 1; f < 3; f++)
    begin
      run(2'(f), 0, 8'h01, 8'h25, 8'h34);
      chk(got1, word(1, 5'h05));
      chk(got2, word(0, 5'h14));
    end
    run(2'h0, 3, 8'h00, 8'h22, 8'h21);
    chk(got1, word(0, 5'h02));
    run(2'h0, 0, 8'h00, 8'h07, 8'h27);
    chk(32'(n1) | playback_ch1_data_out, 32'h0);
    chk(got2, word(0, 5'h07));
    // 32-bit slots span two 16-bit host words
    word_length_in = 2'h3;
    run(2'h0, 0, 8'h00, 8'h21, 8'h01);
    chk(got1, 32'hC302C303);
    chk(playback_ch2_data_out, 32'h0);
    word_length_in = 2'h0;
  endtask
  task automatic test_done();
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // Main sequence
  initial
  begin
    {rstn_in, reg_wr_in, reg_rd_in, reg_addr_in, reg_wdata_in} = 0;
    {frame_format_in, word_length_in} = 4'h0;
    repeat (20) @(negedge clk_in);
    rstn_in = 1'h1;
    t_regs();
    t_scenarios();
    test_done();
  end
endmodule
